// ===== bench/psw_checker.sv
// Purpose: Concurrent checks on the link between controller and device.
// Assumes: One clock pclk; presetn asynchronous, active low.
// Notes:   Edge causes are remembered for four cycles of pclk.
`timescale 1ns/1ps
module psw_checker (
    // System
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Link
    input  wire logic       shift_clock,
    input  wire logic       latch_clock,
    input  wire logic       clear_all_n,
    input  wire logic       output_enable_n,
    input  wire logic       serial_input,
    input  wire logic       serial_output,
    // Device pins
    input  wire logic [7:0] over_current,
    input  wire logic       thermal_hot,
    input  wire logic [7:0] sink_output
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ----------------------------------------------------------------
    // Helper history
    // ----------------------------------------------------------------
    logic [5:0] ev;
    logic [5:0] h1_r, h2_r, h3_r, h4_r;
    logic [5:0] chg;
    logic       ser_cause;
    logic       sink_cause;
    logic [5:0] rise_cnt_r;
    assign ev = {shift_clock, latch_clock, clear_all_n, output_enable_n,
                 thermal_hot, |over_current};
    assign chg = (ev ^ h1_r) | (h1_r ^ h2_r) | (h2_r ^ h3_r) | (h3_r ^ h4_r);
    assign ser_cause = |chg[5:3];
    assign sink_cause = (|chg[4:0]) | ev[0] | h1_r[0] | h2_r[0] | h3_r[0]
                        | h4_r[0];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h1_r       <= 6'h00;
            h2_r       <= 6'h00;
            h3_r       <= 6'h00;
            h4_r       <= 6'h00;
            rise_cnt_r <= 6'h00;
        end else begin
            h1_r <= ev;
            h2_r <= h1_r;
            h3_r <= h2_r;
            h4_r <= h3_r;
            if (latch_clock && !h1_r[4]) begin
                rise_cnt_r <= 6'h00;
            end else if (shift_clock && !h1_r[5] && rise_cnt_r != 6'h3F) begin
                rise_cnt_r <= rise_cnt_r + 6'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    oe_off_a: assert property (
        output_enable_n [*4] |-> sink_output == 8'h00)
        else $error("sinks on while enable is high");
    clear_sink_a: assert property (
        !clear_all_n [*4] |-> sink_output == 8'h00)
        else $error("sinks on while clear is low");
    clear_ser_a: assert property (
        !clear_all_n [*4] |-> !serial_output)
        else $error("serial output set while clear is low");
    thermal_off_a: assert property (
        thermal_hot [*4] |-> sink_output == 8'h00)
        else $error("sinks on while hot");
    ser_edge_a: assert property (
        $changed(serial_output) |-> ser_cause)
        else $error("serial output moved without a link clock edge");
    sink_cause_a: assert property (
        $changed(sink_output) |-> sink_cause)
        else $error("sinks moved without latch, enable or fault");
    latch_count_a: assert property (
        (latch_clock && !h1_r[4]) |-> rise_cnt_r >= 6'h08)
        else $error("latch raised before eight shift clocks");
    data_hold_a: assert property (
        (shift_clock && !h1_r[5]) |=> $stable(serial_input))
        else $error("serial input moved right after shift rise");

    cover property (latch_clock && !h1_r[4]);
    cover property (!output_enable_n && sink_output == 8'hFF);
    cover property (thermal_hot ##4 sink_output == 8'h00);
endmodule

// ===== bench/serial_power_switch_shift_register_tb.sv
// Purpose: Drives the controller over APB and checks the device end to end.
// Assumes: Controller answers with zero wait states; pclk at 10 MHz.
// Notes:   The wire monitor rebuilds sent bytes and readback words.
`timescale 1ns/1ps
module serial_power_switch_shift_register_tb;
    logic        pclk          = 1'b0;
    logic        presetn       = 1'b0;
    logic        psel          = 1'b0;
    logic        penable       = 1'b0;
    logic        pwrite        = 1'b0;
    logic [7:0]  paddr         = 8'h00;
    logic [31:0] pwdata        = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  over_current  = 8'h00;
    logic [7:0]  under_current = 8'h00;
    logic        thermal_hot   = 1'b0;
    logic [7:0]  sink_output;
    int          bad_count     = 0;
    int          checks_done   = 0;
    int          cycles        = 0;
    int          falls         = 0;
    int          n;
    logic        sc_r          = 1'b0;
    logic        lc_r          = 1'b0;
    logic [7:0]  wire_cfg_r    = 8'h00;
    logic [7:0]  sent_cfg_r    = 8'h00;
    logic [23:0] wire_rb_r     = 24'h000000;
    logic [31:0] rd;
    logic [7:0]  pats [5]      = '{8'h00, 8'h01, 8'h80, 8'hA5, 8'hFF};

    psw_if lnk ();
    psw_device psw_device_i (.pclk(pclk), .presetn(presetn), .lnk(lnk.device),
        .over_current(over_current), .under_current(under_current),
        .thermal_hot(thermal_hot), .sink_output(sink_output));
    psw_ctrl psw_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk.ctrl));
    psw_checker psw_checker_i (.pclk(pclk), .presetn(presetn),
        .shift_clock(lnk.shift_clock), .latch_clock(lnk.latch_clock),
        .clear_all_n(lnk.clear_all_n), .output_enable_n(lnk.output_enable_n),
        .serial_input(lnk.serial_input), .serial_output(lnk.serial_output),
        .over_current(over_current), .thermal_hot(thermal_hot),
        .sink_output(sink_output));

    always #50 pclk = ~pclk;

    // ----------------------------------------------------------------
    // Wire monitor and timeout
    // ----------------------------------------------------------------
    always @(posedge pclk) begin
        sc_r <= lnk.shift_clock;
        lc_r <= lnk.latch_clock;
        if (lnk.shift_clock && !sc_r) begin
            wire_cfg_r <= {wire_cfg_r[6:0], lnk.serial_input};
        end
        // Readback bits are taken on the edge that first sees each fall, before the device moves them.
        if (!lnk.shift_clock && sc_r) begin
            wire_rb_r <= {wire_rb_r[22:0], lnk.serial_output};
            falls <= falls + 1;
        end
        if (lnk.latch_clock && !lc_r) begin
            sent_cfg_r <= wire_cfg_r;
            falls <= 0;
        end
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            bad_count = bad_count + 1;
            tally_and_finish();
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [5:0] ref_crc(input logic [7:0] d);
        logic [13:0] v;
        v = {d, 6'h00};
        for (int i = 13; i >= 6; i--) begin
            if (v[i]) begin
                v = v ^ (14'h0043 << (i - 6));
            end
        end
        return v[5:0];
    endfunction

    function automatic logic [23:0] word(input logic [7:0] oc,
        input logic [7:0] os, input logic th, input logic [7:0] d);
        return {oc, os, 1'b0, th, ref_crc(d)};
    endfunction

    // Sends one byte, waits for the readback and checks every view of it.
    task automatic xfer(input logic [7:0] d, input logic [23:0] exp);
        apb(1'b1, psw_pkg::OFF_DATA, {24'h000000, d});
        apb(1'b1, psw_pkg::OFF_CTRL, 32'h00000001);
        n = 0;
        rd = 32'h00000000;
        while (rd[1:0] !== 2'b10 && n < 200) begin
            apb(1'b0, psw_pkg::OFF_STAT, 32'h00000000);
            n = n + 1;
        end
        chk("status", rd[2:0], 3'b010);
        apb(1'b0, psw_pkg::OFF_RB, 32'h00000000);
        chk("readback reg", rd, {8'h00, exp});
        chk("readback wire", wire_rb_r, exp);
        chk("fall count", falls, 24);
        chk("sent byte", sent_cfg_r, d);
        chk("sinks", sink_output, d);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk("sinks after reset", sink_output, 8'h00);
        apb(1'b0, 8'hF0, 32'h00000000);
        chk("unmapped read", rd, 32'h00000000);
        chk("slave error", {31'h0, pslverr}, 32'h00000000);
        foreach (pats[i]) begin
            xfer(pats[i], word(8'h00, 8'h00, 1'b0, pats[i]));
        end
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, psw_pkg::OFF_CTRL, 32'h00000004);
            repeat (4) @(posedge pclk);
            chk("enable off", sink_output, 8'h00);
            apb(1'b1, psw_pkg::OFF_CTRL, 32'h00000000);
            repeat (4) @(posedge pclk);
            chk("enable on", sink_output, 8'hFF);
        end
        over_current  <= 8'h08;
        under_current <= 8'h20;
        repeat (5) @(posedge pclk);
        n = 0;
        repeat (100) begin
            @(posedge pclk);
            n = n + int'(sink_output[3]);
        end
        chk("chop ones", n, 2);
        chk("open short stays on", sink_output[5], 1'b1);
        over_current  <= 8'h00;
        under_current <= 8'h00;
        thermal_hot   <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("thermal off", sink_output, 8'h00);
        thermal_hot <= 1'b0;
        repeat (5) @(posedge pclk);
        chk("thermal resume", sink_output, 8'hFF);
        xfer(8'hFF, word(8'h08, 8'h20, 1'b1, 8'hFF));
        xfer(8'h5A, word(8'h00, 8'h00, 1'b0, 8'h5A));
        // A lasting fault shows in both of two reads in a row.
        under_current <= 8'h02;
        repeat (4) @(posedge pclk);
        repeat (2) begin
            xfer(8'h5A, word(8'h00, 8'h02, 1'b0, 8'h5A));
        end
        under_current <= 8'h00;
        thermal_hot <= 1'b1;
        repeat (3) @(posedge pclk);
        thermal_hot <= 1'b0;
        apb(1'b1, psw_pkg::OFF_CTRL, 32'h00000002);
        repeat (4) @(posedge pclk);
        chk("clear", sink_output, 8'h00);
        apb(1'b1, psw_pkg::OFF_CTRL, 32'h00000000);
        repeat (4) @(posedge pclk);
        chk("after clear", sink_output, 8'h00);
        xfer(8'h3C, word(8'h00, 8'h00, 1'b0, 8'h3C));
        tally_and_finish();
    end
endmodule

// ===== core/psw_chop.sv
// Purpose: Duty chopper for one over-current channel set.
// Assumes: Free-running on pclk.
// Notes:   Gate is high one cycle per chop period.
`timescale 1ns/1ps
module psw_chop (
    // System
    input  wire logic pclk,
    input  wire logic presetn,
    // Gate
    output logic      chop_on
);
    typedef struct packed {
        logic [5:0] cnt;
    } chop_st_t;
    chop_st_t st_r;
    chop_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (st_r.cnt == psw_pkg::CHOP_PERIOD - 6'h01) begin
            st_nxt.cnt = 6'h00;
        end else begin
            st_nxt.cnt = st_r.cnt + 6'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign chop_on = (st_r.cnt == 6'h00);
endmodule

// ===== core/psw_ctrl.sv
// Purpose: APB-driven controller that writes and reads the switch device.
// Assumes: APB slave, zero wait states.
// Notes:   One transaction sends 8 bits, latches, then reads 24 bits.
`timescale 1ns/1ps
module psw_ctrl (
    // APB
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Link
    psw_if.ctrl              lnk
);
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_SHIFT = 3'b001,
        S_LATCH = 3'b011,
        S_READ  = 3'b010,
        S_CHECK = 3'b110
    } cst_t;
    typedef struct packed {
        cst_t        state;
        logic [7:0]  data;
        logic [7:0]  tx;
        logic [23:0] rx;
        logic [4:0]  bits;
        logic [3:0]  div;
        logic        sck;
        logic        lck;
        logic        sin;
        logic        clr_n;
        logic        oe_n;
        logic        crc_err;
        logic        done;
        logic [31:0] rdata;
    } ctl_st_t;
    ctl_st_t st_r;
    ctl_st_t st_nxt;

    always_comb begin
        logic wr;
        logic rd;
        logic tick;
        wr   = psel & penable & pwrite;
        rd   = psel & ~penable & ~pwrite;
        tick = 1'b0;
        st_nxt = st_r;
        if (st_r.div == psw_pkg::HALF_DIV - 4'h1) begin
            st_nxt.div = 4'h0;
            tick = 1'b1;
        end else begin
            st_nxt.div = st_r.div + 4'h1;
        end
        if (rd) begin
            case (paddr)
                psw_pkg::OFF_CTRL: st_nxt.rdata = {29'h0, st_r.oe_n,
                                                   ~st_r.clr_n, 1'b0};
                psw_pkg::OFF_DATA: st_nxt.rdata = {24'h0, st_r.data};
                psw_pkg::OFF_STAT: st_nxt.rdata = {29'h0, st_r.crc_err,
                                     st_r.done, st_r.state != S_IDLE};
                psw_pkg::OFF_RB:   st_nxt.rdata = {8'h0, st_r.rx};
                default:           st_nxt.rdata = 32'h0;
            endcase
        end
        if (wr && paddr == psw_pkg::OFF_CTRL) begin
            st_nxt.clr_n = ~pwdata[psw_pkg::CTL_CLEAR];
            st_nxt.oe_n  = pwdata[psw_pkg::CTL_OE_N];
        end
        if (wr && paddr == psw_pkg::OFF_DATA) begin
            st_nxt.data = pwdata[7:0];
        end
        case (st_r.state)
            S_IDLE: begin
                st_nxt.sck = 1'b0;
                st_nxt.lck = 1'b0;
                if (wr && paddr == psw_pkg::OFF_CTRL
                    && pwdata[psw_pkg::CTL_START]) begin
                    st_nxt.state = S_SHIFT;
                    st_nxt.sin   = st_r.data[7];
                    st_nxt.tx    = {st_r.data[6:0], 1'b0};
                    st_nxt.bits  = 5'h0;
                    st_nxt.done  = 1'b0;
                    st_nxt.div   = 4'h0;
                end
            end
            S_SHIFT: if (tick) begin
                if (!st_r.sck) begin
                    if (st_r.bits == 5'h8) begin
                        st_nxt.state = S_LATCH;
                    end else begin
                        st_nxt.sck = 1'b1;
                    end
                end else begin
                    // The next bit moves on the fall, well clear of a rise.
                    st_nxt.sck  = 1'b0;
                    st_nxt.bits = st_r.bits + 5'h1;
                    st_nxt.sin  = st_r.tx[7];
                    st_nxt.tx   = {st_r.tx[6:0], 1'b0};
                end
            end
            S_LATCH: if (tick) begin
                st_nxt.lck = ~st_r.lck;
                if (st_r.lck) begin
                    st_nxt.state = S_READ;
                    st_nxt.bits  = 5'h0;
                    st_nxt.rx    = 24'h0;
                end
            end
            S_READ: if (tick) begin
                st_nxt.sck = ~st_r.sck;
                if (st_r.sck) begin
                    // Sample just before the falling edge moves the device.
                    st_nxt.rx   = {st_r.rx[22:0], lnk.serial_output};
                    st_nxt.bits = st_r.bits + 5'h1;
                    if (st_r.bits == 5'd23) begin
                        st_nxt.state = S_CHECK;
                    end
                end
            end
            S_CHECK: begin
                st_nxt.crc_err = psw_pkg::crc6(st_r.data)
                                 != st_r.rx[5:0];
                st_nxt.done  = 1'b1;
                st_nxt.state = S_IDLE;
            end
            default: st_nxt.state = S_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r       <= '0;
            st_r.clr_n <= 1'b0;
            st_r.oe_n  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata              = st_r.rdata;
    assign pready              = 1'b1;
    assign pslverr             = 1'b0;
    assign lnk.shift_clock     = st_r.sck;
    assign lnk.latch_clock     = st_r.lck;
    assign lnk.serial_input    = st_r.sin;
    assign lnk.clear_all_n     = st_r.clr_n;
    assign lnk.output_enable_n = st_r.oe_n;
endmodule

// ===== core/psw_device.sv
// Purpose: Serial-in power switch device with fault readback and CRC.
// Assumes: Link pins are synchronous levels; edges detected on pclk.
// Notes:   Sense inputs model the analog comparators.
`timescale 1ns/1ps
module psw_device (
    // System
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Link
    psw_if.device            lnk,
    // Analog sense
    input  wire logic [7:0]  over_current,
    input  wire logic [7:0]  under_current,
    input  wire logic        thermal_hot,
    // Sinks, one means sinking
    output logic      [7:0]  sink_output
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  shift_reg;
        logic [7:0]  store_reg;
        logic [23:0] rb_reg;
        logic        rb_active;
        logic [7:0]  oc_flag;
        logic [7:0]  os_flag;
        logic        th_flag;
        logic        th_trip;
        logic        sck_q;
        logic        lck_q;
        logic        sout;
        logic [7:0]  sink;
    } dev_st_t;
    dev_st_t st_r;
    dev_st_t st_nxt;
    logic    chop_on;
    logic    [7:0] drive_w;

    // ----------------------------------------------------------------
    // Over-current chopper
    // ----------------------------------------------------------------
    // One shared gate paces every chopping channel at the same duty.
    psw_chop psw_chop_i (
        .pclk    (pclk),
        .presetn (presetn),
        .chop_on (chop_on)
    );

    // ----------------------------------------------------------------
    // Per-channel drive
    // ----------------------------------------------------------------
    // A flagged channel still over its limit conducts only while the gate is up.
    for (genvar g = 0; g < psw_pkg::NCH; g++) begin : g_drive
        assign drive_w[g] = st_r.store_reg[g]
                            & (~st_r.oc_flag[g] | ~over_current[g]
                               | chop_on);
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic       s_rise;
        logic       s_fall;
        logic       l_rise;
        s_rise = 1'b0;
        s_fall = 1'b0;
        l_rise = 1'b0;
        st_nxt = st_r;

        // ------------------------------------------------------------
        // Edge detection
        // ------------------------------------------------------------
        // Link pins are sampled once per pclk, so every edge is seen
        // one cycle after it happens on the pin.
        st_nxt.sck_q = lnk.shift_clock;
        st_nxt.lck_q = lnk.latch_clock;
        s_rise = lnk.shift_clock & ~st_r.sck_q;
        s_fall = ~lnk.shift_clock & st_r.sck_q;
        l_rise = lnk.latch_clock & ~st_r.lck_q;

        // ------------------------------------------------------------
        // Fault sensing
        // ------------------------------------------------------------
        // Thermal trip with hysteresis handled by the sense comparator.
        st_nxt.th_trip = thermal_hot;
        // A flag only sets while its channel is switched on.
        for (int i = 0; i < psw_pkg::NCH; i++) begin
            if (st_r.store_reg[i] && over_current[i]) begin
                st_nxt.oc_flag[i] = 1'b1;
            end
            if (st_r.store_reg[i] && under_current[i]) begin
                st_nxt.os_flag[i] = 1'b1;
            end
        end
        if (thermal_hot) begin
            st_nxt.th_flag = 1'b1;
        end

        // ------------------------------------------------------------
        // Shift and readback path
        // ------------------------------------------------------------
        if (s_rise) begin
            st_nxt.shift_reg = {st_r.shift_reg[6:0],
                                lnk.serial_input};
            st_nxt.rb_reg    = {st_r.rb_reg[22:0], 1'b0};
        end
        if (s_fall) begin
            // After the first latch the output carries the readback word;
            // before it, the shift register passes on for cascading.
            if (st_r.rb_active) begin
                st_nxt.sout = st_r.rb_reg[psw_pkg::RB_W-1];
            end else begin
                st_nxt.sout = st_r.shift_reg[7];
            end
        end

        // ------------------------------------------------------------
        // Latch
        // ------------------------------------------------------------
        if (l_rise) begin
            st_nxt.store_reg = st_r.shift_reg;
            // Flags are read out now; a new event this cycle stays set.
            st_nxt.rb_reg = {st_r.oc_flag, st_r.os_flag, 1'b0,
                             st_r.th_flag,
                             psw_pkg::crc6(st_r.shift_reg)};
            // The remainder covers the received byte only.
            st_nxt.rb_active = 1'b1;
            st_nxt.sout = st_r.oc_flag[7];
            st_nxt.oc_flag = over_current & st_r.store_reg;
            st_nxt.os_flag = under_current & st_r.store_reg;
            st_nxt.th_flag = thermal_hot;
        end

        // ------------------------------------------------------------
        // Output drive
        // ------------------------------------------------------------
        // The CRC is read combinationally; shift_reg itself is not touched.
        if (lnk.output_enable_n || st_r.th_trip) begin
            st_nxt.sink = 8'h00;
        end else begin
            st_nxt.sink = drive_w;
        end

        // ------------------------------------------------------------
        // Clear
        // ------------------------------------------------------------
        // Clear comes last so that it wins over every other update except sck_q, lck_q and th_trip.
        if (!lnk.clear_all_n) begin
            st_nxt.shift_reg = psw_pkg::CFG_RESET;
            st_nxt.store_reg = psw_pkg::CFG_RESET;
            st_nxt.rb_reg    = '0;
            st_nxt.rb_active = 1'b0;
            st_nxt.oc_flag   = 8'h00;
            st_nxt.os_flag   = 8'h00;
            st_nxt.th_flag   = 1'b0;
            st_nxt.sout      = 1'b0;
            st_nxt.sink      = 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Pins
    // ----------------------------------------------------------------
    assign sink_output       = st_r.sink;
    assign lnk.serial_output = st_r.sout;
endmodule

// ===== pkg/psw_if.sv
// Purpose: Wires between controller and power switch device.
// Assumes: All pins sampled on pclk.
// Notes:   Clocks of the link are levels sampled on pclk.
`timescale 1ns/1ps
interface psw_if;
    logic shift_clock;
    logic latch_clock;
    logic clear_all_n;
    logic output_enable_n;
    logic serial_input;
    logic serial_output;
    modport device (input shift_clock, latch_clock, clear_all_n,
                    output_enable_n, serial_input, output serial_output);
    modport ctrl (output shift_clock, latch_clock, clear_all_n,
                  output_enable_n, serial_input, input serial_output);
endinterface

// ===== pkg/psw_pkg.sv
// Purpose: Shared constants and types for the serial power switch link.
// Assumes: One system clock pclk at 10 MHz.
// Notes:   Controller register offsets are byte addresses on APB.
package psw_pkg;
    localparam int        NCH        = 8;
    localparam int        RB_W       = 24;
    localparam int        CRC_W      = 6;
    localparam logic [6:0] CRC_POLY  = 7'h43;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Readback word field positions.
    localparam int        RB_OC_LSB  = 16;
    localparam int        RB_OS_LSB  = 8;
    localparam int        RB_TH_BIT  = 6;
    // Over-current chop: on 1 cycle of CHOP_PERIOD, about 2 percent.
    localparam logic [5:0] CHOP_PERIOD = 6'h32;
    // Controller link timing: half period of the shift clock in pclk cycles.
    localparam logic [3:0] HALF_DIV  = 4'h2;
    // Controller APB register offsets.
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_DATA  = 8'h04;
    localparam logic [7:0] OFF_STAT  = 8'h08;
    localparam logic [7:0] OFF_RB    = 8'h0C;
    // Control register bit positions.
    localparam int        CTL_START  = 0;
    localparam int        CTL_CLEAR  = 1;
    localparam int        CTL_OE_N   = 2;

    function automatic logic [5:0] crc6(input logic [7:0] d);
        logic [13:0] v;
        v = {d, 6'h00};
        for (int i = 13; i >= 6; i--) begin
            if (v[i]) begin
                v[i -: 7] = v[i -: 7] ^ CRC_POLY;
            end
        end
        return v[5:0];
    endfunction
endpackage
